// file: dmc_clkgen.sv
// Oversampling clock divider with edge and frame pulses.
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dmc_clkgen
  import dmc_pkg::*;
#(
  parameter logic [7:0] DIV_HALF = 8'h05
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [1:0] osr,
  output logic            mic_clk,
  output logic            rise,
  output logic            fall,
  output logic            frame
);
  dmc_gen_t   g;       // Registered state.
  dmc_gen_t   next_g;  // Next state.
  logic [7:0] ratio;   // Bits per sample period.

  // Ratio decode; the spare code falls back to the widest ratio.
  always_comb begin
    unique case (osr)
      `DMC_OSR_64: ratio = `DMC_RATIO_64;
      `DMC_OSR_32: ratio = `DMC_RATIO_32;
      default:     ratio = `DMC_RATIO_128;
    endcase
  end

  // Toggle every half period; count falls to mark sample periods.
  always_comb begin
    next_g       = g;
    next_g.rise  = 1'b0;
    next_g.fall  = 1'b0;
    next_g.frame = 1'b0;
    if (!run) begin
      // Stopped clock rests low so the next frame starts cleanly.
      next_g = '0;
    end else if (g.cnt == DIV_HALF - 8'h01) begin
      next_g.cnt = 8'h00;
      next_g.clk = !g.clk;
      if (!g.clk) begin
        next_g.rise = 1'b1;
      end else begin
        next_g.fall = 1'b1;
        // A ratio cut mid-period is caught by the >= test.
        if (g.bits >= ratio - 8'h01) begin
          next_g.bits  = 8'h00;
          next_g.frame = 1'b1;
        end else begin
          next_g.bits = g.bits + 8'h01;
        end
      end
    end else begin
      next_g.cnt = g.cnt + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g <= '0;
    end else begin
      g <= next_g;
    end
  end

  assign mic_clk = g.clk;
  assign rise    = g.rise;
  assign fall    = g.fall;
  assign frame   = g.frame;
endmodule

// file: dmc_decim.sv
// Boxcar decimator: sums +/-1 bits over one sample period.
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dmc_decim
  import dmc_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   en,
  input  wire logic                   take,
  input  wire logic                   bit_in,
  input  wire logic                   dump,
  input  wire logic [1:0]             shift,
  output logic [`DMC_WORD_W-1:0]      word,
  output logic                        valid
);
  dmc_dec_t          d;       // Registered state.
  dmc_dec_t          next_d;  // Next state.
  logic signed [8:0] step;    // Contribution of this cycle's bit.
  logic signed [8:0] sum;     // Running sum including this bit.

  // Accumulate; on dump emit one word, scaled so every ratio
  // reaches the same full scale. A boxcar is cheap but aliases.
  always_comb begin
    next_d       = d;
    next_d.valid = 1'b0;
    step = take ? (bit_in ? 9'sh001 : 9'sh1FF) : 9'sh000;
    sum  = d.acc + step;
    if (!en) begin
      next_d.acc = 9'sh000;
    end else if (dump) begin
      next_d.word  = `DMC_WORD_W'(sum) <<< shift;
      next_d.valid = 1'b1;
      next_d.acc   = 9'sh000;
    end else begin
      next_d.acc = sum;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end

  assign word  = d.word;
  assign valid = d.valid;
endmodule

// file: dmc_defs.svh
// Register map, field positions and reset values for the mic capture block.
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_AW         6
`define DMC_WORD_W     16
`define DMC_CTRL_OFS   6'h00
`define DMC_STAT_OFS   6'h04
`define DMC_LEFT_OFS   6'h08
`define DMC_RIGHT_OFS  6'h0C
`define DMC_EN_BIT     0
`define DMC_OSR_LSB    1
`define DMC_OSR_MSB    2
`define DMC_EDGE_LSB   3
`define DMC_EDGE_MSB   4
`define DMC_EDGE_RST   2'h3
`define DMC_OSR_128    2'h0
`define DMC_OSR_64     2'h1
`define DMC_OSR_32     2'h2
`define DMC_RATIO_128  8'h80
`define DMC_RATIO_64   8'h40
`define DMC_RATIO_32   8'h20
`define DMC_RESP_OK    2'h0
`define DMC_RESP_SLV   2'h2
`endif

// file: dmc_mic_model.sv
// Behavioural stereo digital microphone pair sharing one data line.
`timescale 1ns/1ps
module dmc_mic_model #(
  parameter int HOLD_NS = 60
) (
  input  wire logic       mclk,
  input  wire logic [3:0] pat_l,
  input  wire logic [3:0] pat_r,
  output logic            dq
);
  logic [1:0] idx_l;     // Position in the left repeating pattern.
  logic [1:0] idx_r;     // Position in the right repeating pattern.
  realtime    last_edge; // Time of the last clock edge seen.

  initial begin
    dq = 1'b0;
    idx_l = 2'h0;
    idx_r = 2'h0;
    last_edge = 0.0;
  end

  // The left mic places its bit after the fall so it is valid at the rise.
  always @(negedge mclk) begin
    last_edge = $realtime;
    #HOLD_NS;
    dq = pat_l[idx_l];
    idx_l = idx_l + 2'h1;
  end

  // The right mic places its bit after the rise so it is valid at the fall.
  always @(posedge mclk) begin
    last_edge = $realtime;
    #HOLD_NS;
    dq = pat_r[idx_r];
    idx_r = idx_r + 2'h1;
  end

  // With the clock stopped nobody holds the line, so it must not look stable.
  always begin
    #100;
    if ($realtime - last_edge > 400.0) begin
      dq = ~dq;
    end
  end
endmodule

// file: dmc_pkg.sv
// Types shared by the mic capture block and its two helper modules.
`include "dmc_defs.svh"
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_WR_IDLE = 2'b01,
    DMC_WR_RESP = 2'b10
  } dmc_wr_t;
  typedef enum logic [1:0] {
    DMC_RD_IDLE = 2'b01,
    DMC_RD_DATA = 2'b10
  } dmc_rd_t;
  // Software control: enable, ratio code and edge selection.
  typedef struct packed {
    logic       en;
    logic [1:0] osr;
    logic [1:0] edges;
  } dmc_ctrl_t;
  // Clock generator state.
  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
    logic [7:0] bits;
    logic       rise;
    logic       fall;
    logic       frame;
  } dmc_gen_t;
  // Decimator state.
  typedef struct packed {
    logic signed [8:0]        acc;
    logic [`DMC_WORD_W-1:0]   word;
    logic                     valid;
  } dmc_dec_t;
  // Top-level state: bus slave, control, sync and edge pipelines.
  typedef struct packed {
    dmc_ctrl_t        ctrl;
    logic             aw_have;
    logic [`DMC_AW-1:0] aw_addr;
    logic             w_have;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    dmc_wr_t          wr;
    logic [1:0]       bresp;
    dmc_rd_t          rd;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             sync1;
    logic             sync2;
    logic [1:0]       rise_d;
    logic [1:0]       fall_d;
    logic [1:0]       frame_d;
    logic [1:0]       seen;
    logic             analog_en;
  } dmc_main_t;
endpackage

// file: dmc_top.sv
// Digital microphone capture with AXI4-Lite control registers.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dmc_top
  import dmc_pkg::*;
#(
  parameter logic [7:0] DIV_HALF = 8'h05
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`DMC_AW-1:0]     s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`DMC_AW-1:0]     s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        mic_clock_pin_o,
  output logic                        mic_clock_pin_oe_n,
  input  wire logic                   mic_data_pin_i,
  output logic                        mic_data_pin_o,
  output logic                        mic_data_pin_oe_n,
  input  wire logic                   gpio_clock_o,
  input  wire logic                   gpio_clock_oe_n,
  input  wire logic                   gpio_data_o,
  input  wire logic                   gpio_data_oe_n,
  output logic [`DMC_WORD_W-1:0]      adc_left_data,
  output logic                        adc_left_valid,
  output logic [`DMC_WORD_W-1:0]      adc_right_data,
  output logic                        adc_right_valid,
  output logic                        analog_convert_en
);
  localparam int HALF_I = int'(DIV_HALF); // Half period in cycles.

  dmc_main_t                       q;          // Registered state.
  dmc_main_t                       next_q;     // Next state.
  logic                            mic_clk;    // Generated clock.
  logic                            ck_rise;    // Clock went high.
  logic                            ck_fall;    // Clock went low.
  logic                            ck_frame;   // Last fall of period.
  logic [1:0]                      ch_en;      // Channel enables.
  logic [1:0]                      take;       // Bit strobes.
  logic [1:0][`DMC_WORD_W-1:0]     words;      // Decimated words.
  logic [1:0]                      valids;     // Word strobes.
  logic [1:0]                      osr_shift;  // Scale per ratio.
  logic [31:0]                     rd_mux;     // Read data select.
  logic [1:0]                      rd_resp;    // Read answer code.
  logic                            aw_hs;      // Address taken.
  logic                            w_hs;       // Data taken.

  // Divider making the oversampling clock from the bus clock.
  dmc_clkgen #(
    .DIV_HALF (DIV_HALF)
  ) u_clkgen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (q.ctrl.en),
    .osr     (q.ctrl.osr),
    .mic_clk (mic_clk),
    .rise    (ck_rise),
    .fall    (ck_fall),
    .frame   (ck_frame)
  );

  // Full scale is the same for each ratio after this shift.
  always_comb begin
    unique case (q.ctrl.osr)
      `DMC_OSR_64: osr_shift = 2'h1;
      `DMC_OSR_32: osr_shift = 2'h2;
      default:     osr_shift = 2'h0;
    endcase
  end

  // One decimator per channel; channel 0 is left, 1 is right.
  // Edge strobes are delayed two cycles to line up with the
  // synchronised data pin, so each bit is the level at its edge.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign ch_en[c] = q.ctrl.en & q.ctrl.edges[c];
    assign take[c]  = (c == 0 ? q.rise_d[1] : q.fall_d[1])
                    & ch_en[c];
    dmc_decim u_decim (
      .aclk    (aclk),
      .aresetn (aresetn),
      .en      (ch_en[c]),
      .take    (take[c]),
      .bit_in  (q.sync2),
      .dump    (q.frame_d[1]),
      .shift   (osr_shift),
      .word    (words[c]),
      .valid   (valids[c])
    );
  end

  // Pin muxing: in mic mode the clock pin is ours and the data pin
  // is an input; otherwise both pins follow the GPIO function.
  assign mic_clock_pin_o    = q.ctrl.en ? mic_clk : gpio_clock_o;
  assign mic_clock_pin_oe_n = q.ctrl.en ? 1'b0 : gpio_clock_oe_n;
  assign mic_data_pin_o     = gpio_data_o;
  assign mic_data_pin_oe_n  = q.ctrl.en ? 1'b1 : gpio_data_oe_n;

  // Sample stream towards the serial audio interface.
  assign adc_left_data     = words[0];
  assign adc_left_valid    = valids[0];
  assign adc_right_data    = words[1];
  assign adc_right_valid   = valids[1];
  assign analog_convert_en = q.analog_en;

  // Bus handshakes; one write and one read in flight at most.
  assign s_axi_awready = (q.wr == DMC_WR_IDLE) && !q.aw_have;
  assign s_axi_wready  = (q.wr == DMC_WR_IDLE) && !q.w_have;
  assign s_axi_bvalid  = (q.wr == DMC_WR_RESP);
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = (q.rd == DMC_RD_IDLE);
  assign s_axi_rvalid  = (q.rd == DMC_RD_DATA);
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;

  // Read decode; unmapped words answer with a slave error.
  always_comb begin
    rd_mux  = 32'h00000000;
    rd_resp = `DMC_RESP_OK;
    unique case (s_axi_araddr)
      `DMC_CTRL_OFS: begin
        rd_mux[`DMC_EN_BIT]                = q.ctrl.en;
        rd_mux[`DMC_OSR_MSB:`DMC_OSR_LSB]   = q.ctrl.osr;
        rd_mux[`DMC_EDGE_MSB:`DMC_EDGE_LSB] = q.ctrl.edges;
      end
      `DMC_STAT_OFS: rd_mux[2:0] = {q.seen, q.ctrl.en};
      `DMC_LEFT_OFS: rd_mux[`DMC_WORD_W-1:0] = words[0];
      `DMC_RIGHT_OFS: rd_mux[`DMC_WORD_W-1:0] = words[1];
      default: rd_resp = `DMC_RESP_SLV;
    endcase
  end

  // Next-state logic for the whole top level.
  always_comb begin
    next_q = q;
    // Two-flop synchroniser on the data pin.
    next_q.sync1   = mic_data_pin_i;
    next_q.sync2   = q.sync1;
    next_q.rise_d  = {q.rise_d[0], ck_rise};
    next_q.fall_d  = {q.fall_d[0], ck_fall};
    next_q.frame_d = {q.frame_d[0], ck_frame};
    // Analog conversion is blocked while the mic owns the ADCs.
    next_q.analog_en = !q.ctrl.en;
    // Seen flags clear when disabled; a word in the same cycle wins.
    if (!q.ctrl.en) begin
      next_q.seen = 2'h0;
    end
    next_q.seen = next_q.seen | valids;
    // Address and data may arrive in either order.
    if (aw_hs) begin
      next_q.aw_have = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_q.w_have = 1'b1;
      next_q.w_data = s_axi_wdata;
      next_q.w_strb = s_axi_wstrb;
    end
    unique case (q.wr)
      DMC_WR_IDLE: begin
        if (q.aw_have && q.w_have) begin
          next_q.aw_have = 1'b0;
          next_q.w_have  = 1'b0;
          next_q.wr      = DMC_WR_RESP;
          next_q.bresp   = `DMC_RESP_OK;
          unique case (q.aw_addr)
            `DMC_CTRL_OFS: begin
              if (q.w_strb[0]) begin
                next_q.ctrl.en    = q.w_data[`DMC_EN_BIT];
                next_q.ctrl.osr   =
                  q.w_data[`DMC_OSR_MSB:`DMC_OSR_LSB];
                next_q.ctrl.edges =
                  q.w_data[`DMC_EDGE_MSB:`DMC_EDGE_LSB];
              end
            end
            // Read-only words accept and ignore writes.
            `DMC_STAT_OFS, `DMC_LEFT_OFS, `DMC_RIGHT_OFS: begin
              next_q.bresp = `DMC_RESP_OK;
            end
            default: next_q.bresp = `DMC_RESP_SLV;
          endcase
        end
      end
      DMC_WR_RESP: begin
        if (s_axi_bready) begin
          next_q.wr = DMC_WR_IDLE;
        end
      end
      default: next_q.wr = DMC_WR_IDLE;
    endcase
    unique case (q.rd)
      DMC_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_q.rd    = DMC_RD_DATA;
          next_q.rdata = rd_mux;
          next_q.rresp = rd_resp;
        end
      end
      DMC_RD_DATA: begin
        if (s_axi_rready) begin
          next_q.rd = DMC_RD_IDLE;
        end
      end
      default: next_q.rd = DMC_RD_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q            <= '0;
      q.ctrl.edges <= `DMC_EDGE_RST;
      q.wr         <= DMC_WR_IDLE;
      q.rd         <= DMC_RD_IDLE;
      q.analog_en  <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // Checking helpers: falls per period and ratio changes.
  logic [7:0] fall_cnt;  // Falls since the last frame.
  logic       osr_chg;   // Ratio altered inside this period.
  logic [7:0] ratio_m1;  // Expected falls minus one.

  always_comb begin
    unique case (q.ctrl.osr)
      `DMC_OSR_64: ratio_m1 = `DMC_RATIO_64 - 8'h01;
      `DMC_OSR_32: ratio_m1 = `DMC_RATIO_32 - 8'h01;
      default:     ratio_m1 = `DMC_RATIO_128 - 8'h01;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !q.ctrl.en) begin
      fall_cnt <= 8'h00;
      osr_chg  <= 1'b1;
    end else if (ck_frame) begin
      fall_cnt <= 8'h00;
      osr_chg  <= 1'b0;
    end else begin
      if (ck_fall) begin
        fall_cnt <= fall_cnt + 8'h01;
      end
      if (next_q.ctrl.osr != q.ctrl.osr) begin
        osr_chg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_off2;
    !q.ctrl.en ##1 !q.ctrl.en;
  endsequence
  sequence s_on2;
    q.ctrl.en ##1 q.ctrl.en;
  endsequence

  clock_stop_a: assert property (s_off2 |-> !mic_clk)
    else $error("mic clock still runs while disabled");
  clock_runs_a: assert property (
    s_on2 |-> ##[1:HALF_I] ($changed(mic_clock_pin_o) || !q.ctrl.en))
    else $error("mic clock pin stalled in mic mode");
  pin_own_a: assert property (
    q.ctrl.en |-> (!mic_clock_pin_oe_n && mic_data_pin_oe_n))
    else $error("mic pins not owned in mic mode");
  osr_ratio_a: assert property (
    ck_frame && !osr_chg |-> fall_cnt == ratio_m1)
    else $error("sample period length wrong for ratio");
  left_rise_a: assert property (
    take[0] |-> $past(ck_rise, 2))
    else $error("left bit taken away from a rising edge");
  right_fall_a: assert property (
    take[1] |-> $past(ck_fall, 2))
    else $error("right bit taken away from a falling edge");
  edge_sel_a: assert property (
    ck_rise ##2 ch_en[0] |-> take[0])
    else $error("enabled rising edge not captured");
  word_rate_a: assert property (
    valids[0] |-> $past(q.frame_d[1] && ch_en[0]))
    else $error("left word outside its sample period end");
  analog_off_a: assert property (s_on2 |-> !analog_convert_en)
    else $error("analog conversion allowed in mic mode");
endmodule

// file: tb.sv
// Self-checking bench for the digital microphone capture block.
`timescale 1ns/1ps
`include "dmc_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module tb
  import dmc_pkg::*;
;
  localparam logic [1:0] OTAB [4] = '{`DMC_OSR_128, `DMC_OSR_64,
                                      `DMC_OSR_32, 2'h3};
  localparam logic [1:0] ETAB [4] = '{2'h3, 2'h1, 2'h2, 2'h3};
  localparam logic [7:0] RTAB [4] = '{`DMC_RATIO_128, `DMC_RATIO_64,
                                      `DMC_RATIO_32, `DMC_RATIO_128};
  logic        aclk;
  logic        aresetn;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        mic_clock_pin_o, mic_clock_pin_oe_n;
  logic        mic_data_pin_o, mic_data_pin_oe_n;
  logic        gpio_clock_o, gpio_clock_oe_n, gpio_data_o, gpio_data_oe_n;
  logic [15:0] adc_left_data, adc_right_data;
  logic        adc_left_valid, adc_right_valid, analog_convert_en;
  logic        mclk_w, dat_w, mic_dq;
  logic [3:0]  pat_l, pat_r;
  logic [31:0] seed;
  logic [1:0]  cur_edges;   // Channels the current setting enables.
  logic [1:0]  skip;        // First word after enable may hold stale bits.
  logic [33:0] nt;          // Note taken off a queue.
  int          fails, checked;
  int          rises [2];   // Mic clock rises since each channel's last word.
  logic [1:0]  q_wb [$];    // Expected write responses.
  logic [33:0] q_rd [$];    // Expected read response and data.
  logic [23:0] q_w [2][$];  // Expected ratio and word per channel.

  // A released clock pin is held low by the board pull-down.
  assign mclk_w = mic_clock_pin_oe_n ? 1'b0 : mic_clock_pin_o;
  // The mic owns the data line whenever the block does not drive it.
  assign dat_w = mic_data_pin_oe_n ? mic_dq : mic_data_pin_o;

  dmc_top #(.DIV_HALF(8'h04)) u_dmc_top (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .mic_clock_pin_o, .mic_clock_pin_oe_n,
    .mic_data_pin_i(dat_w), .mic_data_pin_o, .mic_data_pin_oe_n,
    .gpio_clock_o, .gpio_clock_oe_n, .gpio_data_o, .gpio_data_oe_n,
    .adc_left_data, .adc_left_valid, .adc_right_data, .adc_right_valid,
    .analog_convert_en);

  dmc_mic_model u_dmc_mic_model (.mclk(mclk_w), .pat_l, .pat_r,
                                 .dq(mic_dq));

  // Clock at 40 MHz; with a half period of four cycles the mic runs at 5 MHz.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Each pattern bit is +1 or -1; four ones in four give full scale.
  function automatic logic [15:0] wexp(input logic [3:0] p);
    return 16'(64 * $countones(p) - 128);
  endfunction

  task automatic stop_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Address and data are offered together and each is dropped when taken.
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    q_wb.push_back(er);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call never re-drives bready at once.
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [5:0] a, input logic [33:0] exp);
    q_rd.push_back(exp);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    // Let an edge pass so a following call never re-drives rready at once.
    @(posedge aclk);
  endtask

  // Outside mic mode both pins must mirror the general-purpose function.
  task automatic gpio_follow(input int n);
    repeat (n) begin
      seed = xs(seed);
      {gpio_clock_o, gpio_clock_oe_n, gpio_data_o,
       gpio_data_oe_n} <= seed[3:0];
      repeat (2) @(posedge aclk);
      `CHK("clk_pin", seed[3:2], {mic_clock_pin_o, mic_clock_pin_oe_n})
      `CHK("dat_pin", seed[1:0], {mic_data_pin_o, mic_data_pin_oe_n})
    end
  endtask

  // Every result but each channel's first word after enable is matched against the oldest note of its stream.
  always @(posedge aclk) begin
    if (aresetn) begin
      if (s_axi_bvalid && s_axi_bready) begin
        nt = 34'(q_wb.pop_front());
        `CHK("bresp", nt[1:0], s_axi_bresp)
      end
      if (s_axi_rvalid && s_axi_rready) begin
        nt = q_rd.pop_front();
        `CHK("read", nt, {s_axi_rresp, s_axi_rdata})
      end
      for (int c = 0; c < 2; c++) begin
        if (c ? adc_right_valid : adc_left_valid) begin
          `CHK("word_gate", 1'b1, cur_edges[c])
          if (!skip[c] && q_w[c].size() > 0) begin
            nt = 34'(q_w[c].pop_front());
            `CHK("word", nt[15:0], c ? adc_right_data : adc_left_data)
            `CHK("bits_per_word", nt[23:16], 8'(rises[c]))
          end
          skip[c] = 1'b0;
          rises[c] = 0;
        end
      end
    end
  end

  // Rising edges on the clock pin are counted between words of each channel.
  always @(posedge mclk_w) begin
    rises[0]++;
    rises[1]++;
  end

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    stop_test();
  end

  initial begin
    seed = 32'h1124;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 48'h0;
    {gpio_clock_o, gpio_clock_oe_n, gpio_data_o, gpio_data_oe_n} = 4'h5;
    {pat_l, pat_r, cur_edges, skip} = 12'h0;
    {fails, checked, rises[0], rises[1]} = 128'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("analog_rst", 1'b1, analog_convert_en)
    axi_rd(`DMC_CTRL_OFS, {`DMC_RESP_OK, 27'h0, `DMC_EDGE_RST,
                           `DMC_OSR_128, 1'b0});
    for (int i = 1; i < 4; i++) axi_rd(6'(4 * i), {`DMC_RESP_OK, 32'h0});
    axi_rd(6'h10, {`DMC_RESP_SLV, 32'h0});
    axi_wr(6'h14, 32'hFFFF_FFFF, `DMC_RESP_SLV);
    axi_wr(`DMC_STAT_OFS, 32'h1, `DMC_RESP_OK);
    axi_rd(`DMC_STAT_OFS, {`DMC_RESP_OK, 32'h0});
    gpio_follow(8);
    // Each setting selects a ratio and the channels in use; the host clears
    // the unused channel so its decimator stays quiet.
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      pat_l <= seed[3:0];
      pat_r <= seed[7:4];
      cur_edges = ETAB[k];
      skip = 2'h3;
      for (int n = 0; n < 3; n++) begin
        if (ETAB[k][0]) q_w[0].push_back({RTAB[k], wexp(seed[3:0])});
        if (ETAB[k][1]) q_w[1].push_back({RTAB[k], wexp(seed[7:4])});
      end
      axi_wr(`DMC_CTRL_OFS, {27'h0, ETAB[k], OTAB[k], 1'b1},
             `DMC_RESP_OK);
      repeat (2) @(posedge aclk);
      `CHK("analog_mic", 1'b0, analog_convert_en)
      `CHK("clk_drive", 1'b0, mic_clock_pin_oe_n)
      `CHK("dat_input", 1'b1, mic_data_pin_oe_n)
      while (q_w[0].size() + q_w[1].size() > 0) @(posedge aclk);
      axi_rd(`DMC_STAT_OFS, {`DMC_RESP_OK, 29'h0, ETAB[k], 1'b1});
      if (ETAB[k][0]) begin
        axi_rd(`DMC_LEFT_OFS, {`DMC_RESP_OK, 16'h0, wexp(pat_l)});
      end
      if (ETAB[k][1]) begin
        axi_rd(`DMC_RIGHT_OFS, {`DMC_RESP_OK, 16'h0, wexp(pat_r)});
      end
      axi_wr(`DMC_CTRL_OFS, {27'h0, ETAB[k], OTAB[k], 1'b0}, `DMC_RESP_OK);
      repeat (2) @(posedge aclk);
      `CHK("analog_off", 1'b1, analog_convert_en)
      gpio_follow(4);
    end
    stop_test();
  end
endmodule
